// ### tx_path_overhead_insert_regs.sv
/*
  Transmit path overhead byte registers and their insertion into the byte
  stream, followed by an output FIFO. Assumes upstream framing logic marks
  each byte's overhead position and drives the enable and overhead bytes in
  the same cycle as the stream byte; all inputs are synchronous to clk_sys.
*/
// Local design decision: strobed register access.
// Behaviour
// - Trace register goes into trace byte where enable low and buffer off.
// - Signal label register resets to 0x13, the ATM payload code.
// - Label register goes into label byte where enable low.
// - Error count field inserted only with status source zero, enable low.
// - Programmed error count clears to zero once inserted.
// - Non-zero programmed count replaces count accumulated last frame.
// - Status read shows pending count, non-zero until inserted.
// - Transmitted remote defect is register bit OR input pin.
// - Register defect bit one drives status defect position high.
// - Bit zero and pin low drive defect position low.
// - Defect bit ignored with status source one or enable high.
// - Enable high takes status bit from serial overhead input.
// - Spare field inserted with status source zero and enable low.
// - User channel register goes into user byte where enable low.
// - First growth register goes into its byte where enable low.
// - Second growth register goes into its byte where enable low.
// - Third growth register goes into its byte where enable low.
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------
// Output byte FIFO
// --------------------------------------------------------------------
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      rd_q;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty
  assign empty     = (wr_q == rd_q);
  assign full      = (wr_q[PW-1:0] == rd_q[PW-1:0]) && (wr_q[PW] != rd_q[PW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[PW-1:0]];

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (in_valid && !full) begin
      mem[wr_q[PW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // byte_fifo

// --------------------------------------------------------------------
// Overhead registers and insertion
// --------------------------------------------------------------------
module tx_path_overhead_insert_regs (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire logic [7:0]            in_data,
  input  wire serial_overhead_input_pkg::oh_pos_t     byte_position,
  input  wire logic [7:0]            overhead_insert_enable_input,
  input  wire logic [7:0]            serial_overhead_input,
  input  wire logic [7:0]            trace_buffer_byte,
  input  wire logic                  remote_defect_input,
  input  wire logic                  far_end_error_pulse,
  input  wire logic                  frame_start,
  output logic                       parallel_byte_valid,
  input  wire logic                  parallel_byte_ready,
  output logic      [7:0]            parallel_byte_output
);

  logic [7:0] trace_q;
  logic [7:0] label_q;
  logic [3:0] err_prog_q;
  logic       rdi_q;
  logic [2:0] spare_q;
  logic [7:0] user_q;
  logic [7:0] growth_q [3];
  logic [1:0] src_q;
  logic [3:0] err_acc_q;
  logic [3:0] err_prev_q;
  logic [7:0] rdata_q;
  logic [7:0] ins_byte;
  logic [7:0] status_own;
  logic [3:0] err_ins;
  logic       accept;
  logic       wr_hit_status;
  logic       err_taken;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Per bit: overhead input where enable high, register value elsewhere
  function automatic logic [7:0] merge(input logic [7:0] own,
                                       input logic [7:0] oh,
                                       input logic [7:0] en);
    merge = (oh & en) | (own & ~en);
  endfunction

  // Saturating error count increment
  function automatic logic [3:0] sat_inc(input logic [3:0] v, input logic inc);
    sat_inc = (inc && v != serial_overhead_input_pkg::ERR_CNT_MAX) ? v + 4'h1 : v;
  endfunction

  assign accept        = in_valid && in_ready;
  assign wr_hit_status = reg_wr && (reg_addr == serial_overhead_input_pkg::OFF_STATUS);

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  // Trace and label bytes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      trace_q <= serial_overhead_input_pkg::RST_TRACE;
      label_q <= serial_overhead_input_pkg::RST_LABEL;
    end else if (reg_wr) begin
      if (reg_addr == serial_overhead_input_pkg::OFF_TRACE) begin
        trace_q <= reg_wdata;
      end
      if (reg_addr == serial_overhead_input_pkg::OFF_LABEL) begin
        label_q <= reg_wdata;
      end
    end
  end

  // Status defect and spare fields
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdi_q   <= serial_overhead_input_pkg::RST_STATUS[serial_overhead_input_pkg::RDI_BIT];
      spare_q <= serial_overhead_input_pkg::RST_STATUS[serial_overhead_input_pkg::SPARE_HI:serial_overhead_input_pkg::SPARE_LO];
    end else if (wr_hit_status) begin
      rdi_q   <= reg_wdata[serial_overhead_input_pkg::RDI_BIT];
      spare_q <= reg_wdata[serial_overhead_input_pkg::SPARE_HI:serial_overhead_input_pkg::SPARE_LO];
    end
  end

  // Programmed error count; a write in the insert cycle wins
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      err_prog_q <= serial_overhead_input_pkg::RST_STATUS[serial_overhead_input_pkg::ERR_HI:serial_overhead_input_pkg::ERR_LO];
    end else if (wr_hit_status) begin
      err_prog_q <= reg_wdata[serial_overhead_input_pkg::ERR_HI:serial_overhead_input_pkg::ERR_LO];
    end else if (err_taken) begin
      err_prog_q <= 4'h0;
    end
  end

  // User channel and growth bytes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      user_q <= serial_overhead_input_pkg::RST_USER;
      for (int i = 0; i < 3; i++) begin
        growth_q[i] <= serial_overhead_input_pkg::RST_GROWTH;
      end
    end else if (reg_wr) begin
      if (reg_addr == serial_overhead_input_pkg::OFF_USER) begin
        user_q <= reg_wdata;
      end
      if (reg_addr == serial_overhead_input_pkg::OFF_GROWTH1) begin
        growth_q[0] <= reg_wdata;
      end
      if (reg_addr == serial_overhead_input_pkg::OFF_GROWTH2) begin
        growth_q[1] <= reg_wdata;
      end
      if (reg_addr == serial_overhead_input_pkg::OFF_GROWTH3) begin
        growth_q[2] <= reg_wdata;
      end
    end
  end

  // Source control: status source select and trace buffer insertion
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      src_q <= serial_overhead_input_pkg::RST_SRC;
    end else if (reg_wr && reg_addr == serial_overhead_input_pkg::OFF_SRC) begin
      src_q <= reg_wdata[1:0];
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!resetn || !reg_rd) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (reg_addr)
        serial_overhead_input_pkg::OFF_TRACE:   rdata_q <= trace_q;
        serial_overhead_input_pkg::OFF_LABEL:   rdata_q <= label_q;
        serial_overhead_input_pkg::OFF_STATUS:  rdata_q <= {err_prog_q, rdi_q, spare_q};
        serial_overhead_input_pkg::OFF_USER:    rdata_q <= user_q;
        serial_overhead_input_pkg::OFF_GROWTH1: rdata_q <= growth_q[0];
        serial_overhead_input_pkg::OFF_GROWTH2: rdata_q <= growth_q[1];
        serial_overhead_input_pkg::OFF_GROWTH3: rdata_q <= growth_q[2];
        serial_overhead_input_pkg::OFF_SRC:     rdata_q <= {6'h00, src_q};
        default:               rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------------
  // Far end error accounting
  // ------------------------------------------------------------------
  // Count error pulses per frame; hand the total on at frame start
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      err_acc_q  <= 4'h0;
      err_prev_q <= 4'h0;
    end else if (frame_start) begin
      err_prev_q <= err_acc_q;
      err_acc_q  <= sat_inc(4'h0, far_end_error_pulse);
    end else begin
      err_acc_q  <= sat_inc(err_acc_q, far_end_error_pulse);
    end
  end

  assign err_ins = (err_prog_q != 4'h0) ? err_prog_q : err_prev_q;

  assign status_own = {err_ins, rdi_q | remote_defect_input, spare_q};

  // count taken only from own source with enable low
  assign err_taken = accept && byte_position == serial_overhead_input_pkg::POS_STATUS &&
                     !src_q[serial_overhead_input_pkg::SRC_STATUS] &&
                     overhead_insert_enable_input[serial_overhead_input_pkg::ERR_HI:serial_overhead_input_pkg::ERR_LO] == 4'h0;

  // ------------------------------------------------------------------
  // Byte insertion
  // ------------------------------------------------------------------
  // registers sampled at each overhead byte position; stream byte passed through at POS_NONE
  always_comb begin
    unique case (byte_position)
      serial_overhead_input_pkg::POS_TRACE:
        ins_byte = src_q[serial_overhead_input_pkg::SRC_TRACE] ? trace_buffer_byte :
                   merge(trace_q, serial_overhead_input, overhead_insert_enable_input);
      serial_overhead_input_pkg::POS_LABEL:
        ins_byte = merge(label_q, serial_overhead_input, overhead_insert_enable_input);
      serial_overhead_input_pkg::POS_STATUS:
        ins_byte = src_q[serial_overhead_input_pkg::SRC_STATUS] ? serial_overhead_input :
                   merge(status_own, serial_overhead_input, overhead_insert_enable_input);
      serial_overhead_input_pkg::POS_USER:
        ins_byte = merge(user_q, serial_overhead_input, overhead_insert_enable_input);
      serial_overhead_input_pkg::POS_GROWTH1:
        ins_byte = merge(growth_q[0], serial_overhead_input, overhead_insert_enable_input);
      serial_overhead_input_pkg::POS_GROWTH2:
        ins_byte = merge(growth_q[1], serial_overhead_input, overhead_insert_enable_input);
      serial_overhead_input_pkg::POS_GROWTH3:
        ins_byte = merge(growth_q[2], serial_overhead_input, overhead_insert_enable_input);
      default:
        ins_byte = in_data;
    endcase
  end

  // Output buffering; a stalled sink back-pressures the stream input
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (serial_overhead_input_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (ins_byte),
    .out_valid (parallel_byte_valid),
    .out_ready (parallel_byte_ready),
    .out_data  (parallel_byte_output)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_status_own;
    accept && byte_position == serial_overhead_input_pkg::POS_STATUS && !src_q[serial_overhead_input_pkg::SRC_STATUS];
  endsequence

  sequence s_err_placed;
    s_status_own ##0 overhead_insert_enable_input[7:4] == 4'h0 ##0 !wr_hit_status;
  endsequence

  chk_trace_insert: assert property (byte_position == serial_overhead_input_pkg::POS_TRACE && !src_q[1] &&
    overhead_insert_enable_input == 8'h00 |-> ins_byte == trace_q)
    else $error("trace byte not from register");

  chk_label_reset: assert property ($rose(resetn) |-> label_q == 8'h13)
    else $error("label reset value wrong");

  chk_label_insert: assert property (byte_position == serial_overhead_input_pkg::POS_LABEL &&
    overhead_insert_enable_input == 8'h00 |-> ins_byte == label_q)
    else $error("label byte not from register");

  chk_err_insert: assert property (s_err_placed |-> ins_byte[7:4] == err_ins)
    else $error("error count not inserted");

  chk_err_clear: assert property (s_err_placed |=> err_prog_q == 4'h0)
    else $error("error count not cleared");

  chk_err_override: assert property (s_err_placed ##0 err_prog_q != 4'h0
    |-> ins_byte[7:4] == err_prog_q)
    else $error("programmed count not used");

  chk_pending_read: assert property (reg_rd && reg_addr == serial_overhead_input_pkg::OFF_STATUS
    |=> reg_rdata[7:4] == $past(err_prog_q))
    else $error("pending count not read back");

  chk_rdi_or: assert property (s_status_own ##0 !overhead_insert_enable_input[3]
    |-> ins_byte[3] == (rdi_q | remote_defect_input))
    else $error("defect bit not ORed");

  chk_oh_source: assert property (byte_position == serial_overhead_input_pkg::POS_STATUS &&
    src_q[0] |-> ins_byte == serial_overhead_input)
    else $error("status byte not from overhead input");

  chk_spare_insert: assert property (s_status_own ##0 overhead_insert_enable_input[2:0] == 3'h0
    |-> ins_byte[2:0] == spare_q)
    else $error("spare field not inserted");

  chk_growth_three: assert property (byte_position == serial_overhead_input_pkg::POS_GROWTH3 &&
    overhead_insert_enable_input == 8'h00 |-> ins_byte == growth_q[2])
    else $error("growth three byte wrong");

  chk_user_write: assert property (reg_wr && reg_addr == serial_overhead_input_pkg::OFF_USER
    |=> user_q == $past(reg_wdata))
    else $error("user channel write lost");

endmodule // tx_path_overhead_insert_regs

`default_nettype wire

// ### serial_overhead_input_pkg.sv
/*
  Constants for the transmit path overhead insertion block: register offsets,
  reset values, field positions, stream positions and buffer depth.
  Assumes an 8-bit register port and an 8-bit parallel byte stream.
*/
`default_nettype none

package serial_overhead_input_pkg;

  // ------------------------------------------------------------------
  // Register port and offsets
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] OFF_TRACE   = 8'h47;
  localparam logic [7:0] OFF_LABEL   = 8'h48;
  localparam logic [7:0] OFF_STATUS  = 8'h49;
  localparam logic [7:0] OFF_USER    = 8'h4a;
  localparam logic [7:0] OFF_GROWTH1 = 8'h4b;
  localparam logic [7:0] OFF_GROWTH2 = 8'h4c;
  localparam logic [7:0] OFF_GROWTH3 = 8'h4d;
  localparam logic [7:0] OFF_SRC     = 8'h4e;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_TRACE  = 8'h00;
  localparam logic [7:0] RST_LABEL  = 8'h13;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_USER   = 8'h00;
  localparam logic [7:0] RST_GROWTH = 8'h00;
  localparam logic [1:0] RST_SRC    = 2'h0;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned ERR_HI     = 7;
  localparam int unsigned ERR_LO     = 4;
  localparam int unsigned RDI_BIT    = 3;
  localparam int unsigned SPARE_HI   = 2;
  localparam int unsigned SPARE_LO   = 0;
  localparam int unsigned SRC_STATUS = 0;
  localparam int unsigned SRC_TRACE  = 1;

  localparam logic [3:0] ERR_CNT_MAX = 4'hf;
  localparam int unsigned FIFO_DEPTH = 8;

  // Overhead byte position carried beside each stream byte
  typedef enum logic [2:0] {
    POS_NONE, POS_TRACE, POS_LABEL, POS_STATUS,
    POS_USER, POS_GROWTH1, POS_GROWTH2, POS_GROWTH3
  } oh_pos_t;

endpackage

`default_nettype wire

// ### upstream_src.sv
/*
  Model of the upstream path overhead source and framing logic.
  Assumes the block's stream input side and one clock, clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module upstream_src (
  input  wire logic         clk_sys,
  input  wire logic         in_ready,
  output logic              in_valid,
  output logic [7:0]        in_data,
  output serial_overhead_input_pkg::oh_pos_t byte_position,
  output logic [7:0]        overhead_insert_enable_input,
  output logic [7:0]        serial_overhead_input,
  output logic              far_end_error_pulse,
  output logic              frame_start
);
  // Idle values at time zero
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    byte_position = serial_overhead_input_pkg::POS_NONE;
    overhead_insert_enable_input = 8'h00;
    serial_overhead_input = 8'h00;
    far_end_error_pulse = 1'b0;
    frame_start = 1'b0;
  end

  // overhead supplied beside byte
  // One byte held until accepted; released lines show the inverse
  task automatic send(input serial_overhead_input_pkg::oh_pos_t pos, input logic [7:0] en, input logic [7:0] oh,
                      input logic [7:0] dat, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk_sys);
    in_valid <= 1'b1;
    byte_position <= pos;
    overhead_insert_enable_input <= en;
    serial_overhead_input <= oh;
    in_data <= dat;
    for (n = 0; n < 50 && !ok; n++) begin
      @(negedge clk_sys);
      ok = (in_ready === 1'b1);
      @(posedge clk_sys);
    end
    in_valid <= 1'b0;
    byte_position <= serial_overhead_input_pkg::POS_NONE;
    overhead_insert_enable_input <= ~en;
    serial_overhead_input <= ~oh;
    in_data <= ~dat;
  endtask

  // One frame carrying n error pulses, closed by the next frame start
  task automatic frame_errors(input int n);
    @(posedge clk_sys);
    frame_start <= 1'b1;
    @(posedge clk_sys);
    frame_start <= 1'b0;
    repeat (n) begin
      far_end_error_pulse <= 1'b1;
      @(posedge clk_sys);
      far_end_error_pulse <= 1'b0;
      @(posedge clk_sys);
    end
    frame_start <= 1'b1;
    @(posedge clk_sys);
    frame_start <= 1'b0;
  endtask
endmodule // upstream_src

`default_nettype wire

// ### tb_tx_path_overhead_insert_regs.sv
/*
  Self-checking testbench for the overhead insertion block.
  Assumes upstream_src as the stream source and a sink driven here.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_tx_path_overhead_insert_regs;
  logic              clk_sys, resetn, reg_wr, reg_rd, in_valid, in_ready, rdi_in, err_p, fstart;
  logic              out_valid, out_ready;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, in_data, en, oh, tbuf, out_data, rd_val;
  serial_overhead_input_pkg::oh_pos_t pos;
  int                bad_count, cmp_count;

  // ------------------------------------------------------------------
  // Clock, instances
  // ------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  upstream_src src (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data),
    .byte_position(pos), .overhead_insert_enable_input(en), .serial_overhead_input(oh),
    .far_end_error_pulse(err_p), .frame_start(fstart));

  tx_path_overhead_insert_regs uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .byte_position(pos),
    .overhead_insert_enable_input(en), .serial_overhead_input(oh), .trace_buffer_byte(tbuf),
    .remote_defect_input(rdi_in), .far_end_error_pulse(err_p), .frame_start(fstart),
    .parallel_byte_valid(out_valid), .parallel_byte_ready(out_ready), .parallel_byte_output(out_data));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic timeout(input string nm);
    bad_count++;
    $display("BAD %s expected handshake seen none", nm);
    give_verdict();
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic reg_check(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk(nm, exp, rd_val);
  endtask

  task automatic expect_out(input string nm, input logic [7:0] exp);
    int n;
    bit seen;
    seen = 1'b0;
    for (n = 0; n < 50 && !seen; n++) begin
      @(negedge clk_sys);
      if (out_valid === 1'b1) begin
        seen = 1'b1;
        chk(nm, exp, out_data);
      end
      @(posedge clk_sys);
    end
    if (!seen) timeout(nm);
  endtask

  task automatic ins(input string nm, input serial_overhead_input_pkg::oh_pos_t p, input logic [7:0] e,
                     input logic [7:0] o, input logic [7:0] exp);
    bit ok;
    src.send(p, e, o, 8'h00, ok);
    if (!ok) timeout(nm);
    expect_out(nm, exp);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    int i;
    for (i = 8'h47; i <= 8'h4e; i++) begin
      reg_check("reset value", 8'(i), (i == 8'h48) ? 8'h13 : 8'h00);
    end
    reg_write(8'h50, 8'h77);
    reg_check("unmapped", 8'h50, 8'h00);
  endtask

  task automatic t_bytes();
    serial_overhead_input_pkg::oh_pos_t ps [6] = '{serial_overhead_input_pkg::POS_TRACE, serial_overhead_input_pkg::POS_LABEL, serial_overhead_input_pkg::POS_USER,
                                  serial_overhead_input_pkg::POS_GROWTH1, serial_overhead_input_pkg::POS_GROWTH2, serial_overhead_input_pkg::POS_GROWTH3};
    logic [7:0] of [6] = '{8'h47, 8'h48, 8'h4a, 8'h4b, 8'h4c, 8'h4d};
    int i;
    for (i = 0; i < 6; i++) reg_write(of[i], 8'h31 + 8'(i * 17));
    for (i = 0; i < 6; i++) begin
      reg_check("byte reg", of[i], 8'h31 + 8'(i * 17));
      ins("byte insert", ps[i], 8'h00, 8'hee, 8'h31 + 8'(i * 17));
    end
    reg_write(8'h48, 8'h5c);
    ins("label rewrite", serial_overhead_input_pkg::POS_LABEL, 8'h00, 8'h00, 8'h5c);
    ins("user from input", serial_overhead_input_pkg::POS_USER, 8'hff, 8'hc3, 8'hc3);
    tbuf <= 8'h66;
    reg_write(8'h4e, 8'h02);
    ins("trace buffer", serial_overhead_input_pkg::POS_TRACE, 8'h00, 8'h00, 8'h66);
    reg_write(8'h4e, 8'h00);
  endtask

  task automatic t_status();
    reg_write(8'h49, 8'h5a);
    reg_check("pending count", 8'h49, 8'h5a);
    ins("status insert", serial_overhead_input_pkg::POS_STATUS, 8'h00, 8'hff, 8'h5a);
    reg_check("count cleared", 8'h49, 8'h0a);
    ins("status again", serial_overhead_input_pkg::POS_STATUS, 8'h00, 8'hff, 8'h0a);
    reg_write(8'h49, 8'h3d);
    ins("status mixed", serial_overhead_input_pkg::POS_STATUS, 8'hf0, 8'ha0, 8'had);
    reg_check("count kept", 8'h49, 8'h3d);
    reg_write(8'h49, 8'h00);
  endtask

  task automatic t_rdi();
    rdi_in <= 1'b1;
    ins("defect pin", serial_overhead_input_pkg::POS_STATUS, 8'h00, 8'hff, 8'h08);
    rdi_in <= 1'b0;
    ins("defect low", serial_overhead_input_pkg::POS_STATUS, 8'h00, 8'hff, 8'h00);
    reg_write(8'h49, 8'h08);
    ins("defect bit enable", serial_overhead_input_pkg::POS_STATUS, 8'h08, 8'h00, 8'h00);
    reg_write(8'h4e, 8'h01);
    reg_write(8'h49, 8'h78);
    ins("status source", serial_overhead_input_pkg::POS_STATUS, 8'h00, 8'h94, 8'h94);
    reg_check("count held", 8'h49, 8'h78);
    reg_write(8'h4e, 8'h00);
    reg_write(8'h49, 8'h00);
  endtask

  task automatic t_count();
    src.frame_errors(3);
    ins("accumulated count", serial_overhead_input_pkg::POS_STATUS, 8'h00, 8'hff, 8'h30);
    reg_write(8'h49, 8'h91);
    ins("programmed count", serial_overhead_input_pkg::POS_STATUS, 8'h00, 8'hff, 8'h91);
    src.frame_errors(0);
    reg_write(8'h49, 8'h00);
  endtask

  task automatic t_fifo();
    int i;
    bit ok;
    out_ready <= 1'b0;
    for (i = 0; i < serial_overhead_input_pkg::FIFO_DEPTH; i++) begin
      src.send(serial_overhead_input_pkg::POS_NONE, 8'h00, 8'h00, 8'h10 + 8'(i), ok);
      if (!ok) timeout("fifo fill");
    end
    @(negedge clk_sys);
    chk("full refuses", 8'h00, {7'h00, in_ready});
    @(posedge clk_sys);
    out_ready <= 1'b1;
    for (i = 0; i < serial_overhead_input_pkg::FIFO_DEPTH; i++) expect_out("fifo order", 8'h10 + 8'(i));
    @(negedge clk_sys);
    chk("fifo empty", 8'h00, {7'h00, out_valid});
  endtask

  // Reset in mid-run brings the label back to its reset value
  task automatic t_rerun();
    reg_write(8'h48, 8'h21);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    reg_check("label after reset", 8'h48, 8'h13);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    bad_count = 0;
    cmp_count = 0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rdi_in = 1'b0;
    tbuf = 8'h00;
    out_ready = 1'b1;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_bytes();
    t_status();
    t_rdi();
    t_count();
    t_fifo();
    t_rerun();
    give_verdict();
  end
endmodule // tb_tx_path_overhead_insert_regs

`default_nettype wire
